// ===== rtl/byte_port_glue.sv
// byte-port glue: packs/unpacks 32-bit words on the 8-bit muxed port
// ----------------------------------------------------------------
// Notes on behaviour
// RULE1 - copy edge with strobe low captures word
// RULE2 - recapture each edge, repeats are harmless
// RULE3 - option: capture on strobe release, separate
// RULE4 - shared holding register in copy scheme
// RULE5 - bytes return most significant first
// RULE6 - lane counter counts copies, clears otherwise
// RULE7 - lane 0..3 selects bits 31..0 bytes
// RULE8 - unpack: enable low, strobe high, direction low
// RULE9 - drive bus on direction or unpack
// RULE10 - unpack steered by enable, direction, copy
// RULE11 - first byte driven without copy pulse
// RULE12 - boot port: 24-bit address, three cycles
// RULE13 - micro port: 8..25 bits, 1..4 bytes
// RULE14 - write bytes shift in, first lands low
// RULE15 - processor set to mode 3, 32/32
// RULE16 - reset clears lane counter and holding
// ----------------------------------------------------------------
`timescale 1ns/100ps
module byte_port_glue #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic aclk, // 125 MHz system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic copy_pulse, // processor copy pulse pin
    input wire logic read_strobe_n, // read strobe pin, active low
    input wire logic bus_output_enable_n, // output-enable pin, active low
    input wire logic bus_direction, // direction pin, high on writes
    input wire logic addr_latch_n, // address latch enable, active low
    input wire logic [7:0] muxed_byte_bus_i, // muxed bus level seen
    output logic [7:0] muxed_byte_bus_o, // byte we drive
    output logic muxed_byte_bus_oe, // high while we drive
    input wire logic [glue_pkg::AXI_AW-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address taken
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte lanes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data taken
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // response valid
    input wire logic s_axi_bready, // response taken
    input wire logic [glue_pkg::AXI_AW-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address taken
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data taken
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire [12:0] pin_raw = {addr_latch_n, read_strobe_n, bus_output_enable_n,
                           bus_direction, copy_pulse, muxed_byte_bus_i};
    logic [12:0] pin_meta_q; // first stage, read only by second
    logic [12:0] pin_q; // safe copy of the pins
    logic cp_prev_q; // copy pulse one cycle ago
    logic rd_prev_q; // strobe one cycle ago
    logic ale_prev_q; // latch enable one cycle ago
    // two flops per pin; the bus is sampled every clock and used only while qualified
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_q <= 13'h1c00;
            pin_q <= 13'h1c00;
            cp_prev_q <= 1'b0;
            rd_prev_q <= 1'b1;
            ale_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= pin_raw;
            pin_q <= pin_meta_q;
            cp_prev_q <= pin_q[8];
            rd_prev_q <= pin_q[11];
            ale_prev_q <= ~pin_q[12];
        end
    end
    wire [7:0] bus_s = pin_q[7:0];
    wire cp_s = pin_q[8];
    wire dir_s = pin_q[9];
    wire oe_n_s = pin_q[10];
    wire rd_n_s = pin_q[11];
    wire ale_s = ~pin_q[12];
    wire cp_rise = cp_s & ~cp_prev_q;
    wire rd_rise = rd_n_s & ~rd_prev_q;
    wire ale_fall = ale_prev_q & ~ale_s;
    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q; // steering bits
    logic [31:0] rd_word_q; // word the wide device returns
    logic ovf_q; // sticky: packed word dropped
    wire sep = ctrl_q[glue_pkg::CTRL_SEP_BIT];
    wire boot = ctrl_q[glue_pkg::CTRL_BOOT_BIT];
    wire [4:0] abits = ctrl_q[glue_pkg::CTRL_ABITS_LSB +: 5];
    // ----------------------------------------------------------------
    // phase decode
    // ----------------------------------------------------------------
    // RULE14 write phase
    wire wr_phase = ~oe_n_s & dir_s;
    // RULE8 unpack qualifier; RULE10 copy edges late are still counted
    wire unpack_en = ~oe_n_s & ~dir_s & rd_n_s;
    // ----------------------------------------------------------------
    // holding registers
    // ----------------------------------------------------------------
    logic [31:0] hold_q; // shared pack/capture register
    logic [31:0] rd_hold_q; // read word in the separate scheme
    logic [1:0] wbyte_q; // write bytes seen this phase
    wire [31:0] packed_word = {bus_s, hold_q[31:8]};
    // RULE1 RULE2 RULE4 RULE14 RULE16 shared shift and recapture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q <= '0;
        end else if (cp_rise && wr_phase) begin
            hold_q <= packed_word;
        end else if (cp_rise && !rd_n_s && !sep) begin
            hold_q <= rd_word_q;
        end
    end
    // RULE3 separate capture on strobe release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_hold_q <= '0;
        end else if (sep && rd_rise) begin
            rd_hold_q <= rd_word_q;
        end
    end
    // write byte counter, cleared outside the write phase
    always_ff @(posedge aclk) begin
        if (!aresetn || !wr_phase) begin
            wbyte_q <= '0;
        end else if (cp_rise) begin
            wbyte_q <= wbyte_q + 2'h1;
        end
    end
    // ----------------------------------------------------------------
    // unpack path
    // ----------------------------------------------------------------
    logic [1:0] lane_q; // byte lane counter
    wire [31:0] rd_src = sep ? rd_hold_q : hold_q;
    // RULE7 RULE5 lane 0 selects the top byte
    wire [7:0] sel_byte = rd_src[{~lane_q, 3'h0} +: 8];
    // RULE6 RULE16 counts copy edges, zero between reads
    always_ff @(posedge aclk) begin
        if (!aresetn || !unpack_en) begin
            lane_q <= '0;
        end else if (cp_rise) begin
            lane_q <= lane_q + 2'h1;
        end
    end
    // RULE9 RULE11 byte and drive enable registered onto the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            muxed_byte_bus_o <= '0;
            muxed_byte_bus_oe <= 1'b0;
        end else begin
            muxed_byte_bus_o <= sel_byte;
            muxed_byte_bus_oe <= dir_s | unpack_en;
        end
    end
    // ----------------------------------------------------------------
    // packed write words into the buffer
    // ----------------------------------------------------------------
    wire push = cp_rise & wr_phase & (wbyte_q == glue_pkg::LANE_LAST);
    wire buf_in_ready;
    wire buf_out_valid;
    wire [31:0] buf_out_data;
    wire [$clog2(BUF_DEPTH+1)-1:0] buf_level;
    wire pop;
    word_buffer #(.WIDTH(32), .DEPTH(BUF_DEPTH)) u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(packed_word),
        .out_valid(buf_out_valid),
        .out_ready(pop),
        .out_data(buf_out_data),
        .level(buf_level)
    );
    // ----------------------------------------------------------------
    // address latch
    // ----------------------------------------------------------------
    logic [2:0] acnt_q; // address bytes taken
    logic [31:0] ash_q; // address shifter
    logic [31:0] addr_q; // last complete address
    // RULE12 RULE13 bytes needed and width kept
    wire [2:0] need = boot ? glue_pkg::BOOT_ADDR_BYTES : 3'(({1'b0, abits} + 6'h7) >> 3);
    wire [31:0] amask = boot ? glue_pkg::BOOT_ADDR_MASK : ((32'h1 << abits) - 32'h1);
    // one byte per clock while latch enable is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acnt_q <= '0;
            ash_q <= '0;
            addr_q <= '0;
        end else begin
            if (ale_s && acnt_q < need) begin
                ash_q <= {ash_q[23:0], bus_s};
                acnt_q <= acnt_q + 3'h1;
            end else if (!ale_s) begin
                acnt_q <= '0;
            end
            if (ale_fall) addr_q <= ash_q & amask;
        end
    end
    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    // address and data taken together, both ready flops load the same term
    wire wr_take = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    wire rd_take = s_axi_arready & s_axi_arvalid;
    wire [7:0] wa = s_axi_awaddr;
    wire [7:0] ra = s_axi_araddr;
    wire w_ctrl = (wa == glue_pkg::OFF_CTRL);
    wire w_rdw = (wa == glue_pkg::OFF_RDWORD);
    wire w_stat = (wa == glue_pkg::OFF_STATUS);
    wire w_ok = w_ctrl | w_rdw | w_stat;
    wire [31:0] status = {25'h0, buf_out_valid, 2'(buf_level), unpack_en, lane_q, ovf_q};
    wire r_ok = (ra == glue_pkg::OFF_CTRL) | (ra == glue_pkg::OFF_RDWORD) |
                (ra == glue_pkg::OFF_STATUS) | (ra == glue_pkg::OFF_WRWORD) |
                (ra == glue_pkg::OFF_ADDR) | (ra == glue_pkg::OFF_HOLD);
    wire [31:0] rmux = (ra == glue_pkg::OFF_CTRL) ? ctrl_q :
                       (ra == glue_pkg::OFF_RDWORD) ? rd_word_q :
                       (ra == glue_pkg::OFF_STATUS) ? status :
                       (ra == glue_pkg::OFF_WRWORD) ? (buf_out_valid ? buf_out_data : 32'h0) :
                       (ra == glue_pkg::OFF_ADDR) ? addr_q :
                       (ra == glue_pkg::OFF_HOLD) ? hold_q : 32'h0;
    // reading the write word register pops the oldest word
    assign pop = rd_take & (ra == glue_pkg::OFF_WRWORD);
    wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire [31:0] ctrl_wr = (ctrl_q & ~wmask) | (s_axi_wdata & wmask);
    wire [4:0] ab_in = ctrl_wr[glue_pkg::CTRL_ABITS_LSB +: 5];
    // width is clamped so the latch never sees an illegal size
    wire [4:0] ab_cl = (ab_in < glue_pkg::ABITS_MIN) ? glue_pkg::ABITS_MIN :
                       (ab_in > glue_pkg::ABITS_MAX) ? glue_pkg::ABITS_MAX : ab_in;
    wire ovf_clr = wr_take & w_stat & s_axi_wstrb[0] & s_axi_wdata[glue_pkg::STAT_OVF_BIT];
    // write channel handshake and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= glue_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_ok ? glue_pkg::RESP_OKAY : glue_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // register writes; a dropped word beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= glue_pkg::CTRL_RST;
            rd_word_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            if (wr_take && w_ctrl) begin
                ctrl_q <= {19'h0, ab_cl, 6'h0, ctrl_wr[1:0]};
            end
            if (wr_take && w_rdw) rd_word_q <= ctrl_wr & wmask | rd_word_q & ~wmask;
            if (push && !buf_in_ready) ovf_q <= 1'b1;
            else if (ovf_clr) ovf_q <= 1'b0;
        end
    end
    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= glue_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rmux;
                s_axi_rresp <= r_ok ? glue_pkg::RESP_OKAY : glue_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_read_release;
        $rose(rd_n_s) && !oe_n_s && !dir_s;
    endsequence
    sequence s_still_read;
        !oe_n_s && !dir_s && rd_n_s;
    endsequence
    property p_capture;
        cp_rise && !rd_n_s && !wr_phase && !sep |=> hold_q == $past(rd_word_q);
    endproperty
    a_capture: assert property (p_capture) else $error("read word not captured"); // RULE1
    property p_sep_capture;
        sep && rd_rise |=> rd_hold_q == $past(rd_word_q) && $stable(hold_q);
    endproperty
    a_sep_capture: assert property (p_sep_capture) else $error("separate capture failed"); // RULE3
    property p_shift_in;
        cp_rise && wr_phase |=> hold_q[31:24] == $past(bus_s) && hold_q[23:0] == $past(hold_q[31:8]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("write byte not shifted"); // RULE14
    property p_lane_clear;
        !unpack_en |=> lane_q == 2'h0;
    endproperty
    a_lane_clear: assert property (p_lane_clear) else $error("lane not cleared"); // RULE6
    property p_lane_step;
        unpack_en && cp_rise |=> lane_q == 2'($past(lane_q) + 2'h1);
    endproperty
    a_lane_step: assert property (p_lane_step) else $error("lane did not step"); // RULE6
    property p_first_byte;
        s_read_release ##1 s_still_read |=> muxed_byte_bus_oe && muxed_byte_bus_o == $past(rd_src[31:24]);
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("first byte late"); // RULE11
    property p_last_byte;
        unpack_en && lane_q == 2'h3 |=> muxed_byte_bus_o == $past(rd_src[7:0]);
    endproperty
    a_last_byte: assert property (p_last_byte) else $error("last lane wrong byte"); // RULE7
    property p_drive;
        ##1 muxed_byte_bus_oe == $past(dir_s || unpack_en);
    endproperty
    a_drive: assert property (p_drive) else $error("bus drive enable wrong"); // RULE9
    property p_boot_addr;
        boot && ale_fall |=> addr_q[31:24] == 8'h00;
    endproperty
    a_boot_addr: assert property (p_boot_addr) else $error("boot address over 24 bits"); // RULE12
endmodule : byte_port_glue

// ===== rtl/glue_pkg.sv
// constants shared by the byte-port glue controller and its testbench
package glue_pkg;
    // ----------------------------------------------------------------
    // register map (byte offsets, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00; // steering bits
    localparam logic [7:0] OFF_RDWORD = 8'h04; // wide device read word
    localparam logic [7:0] OFF_STATUS = 8'h08; // live state and sticky flag
    localparam logic [7:0] OFF_WRWORD = 8'h0c; // packed write word, read pops
    localparam logic [7:0] OFF_ADDR = 8'h10; // last latched address
    localparam logic [7:0] OFF_HOLD = 8'h14; // shared holding register
    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_SEP_BIT = 0; // separate read capture on strobe release
    localparam int CTRL_BOOT_BIT = 1; // boot memory port address mode
    localparam int CTRL_ABITS_LSB = 8; // micro port address width, 5 bits
    localparam logic [4:0] ABITS_MIN = 5'h08;
    localparam logic [4:0] ABITS_MAX = 5'h19;
    localparam logic [31:0] CTRL_RST = 32'h0000_1900;
    localparam int STAT_OVF_BIT = 0; // write word dropped, write one to clear
    localparam logic [2:0] BOOT_ADDR_BYTES = 3'h3;
    localparam logic [31:0] BOOT_ADDR_MASK = 32'h00ff_ffff;
    localparam logic [1:0] LANE_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // processor port setup this glue expects (mode 3, 32/32 sizes)
    localparam logic [3:0] PORT_MODE_EXPECTED = 4'h3;
    localparam logic [7:0] ADC_EXPECTED = 8'h33;
endpackage : glue_pkg

// ===== rtl/word_buffer.sv
// small valid/ready buffer for packed write words
`timescale 1ns/100ps
module word_buffer #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // offered word
    output logic out_valid, // word available
    input wire logic out_ready, // consumer takes word
    output logic [WIDTH-1:0] out_data, // oldest word
    output logic [$clog2(DEPTH+1)-1:0] level // words held
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem_q [DEPTH]; // entry storage
    logic [PW-1:0] wr_ptr_q; // next write slot
    logic [PW-1:0] rd_ptr_q; // oldest slot
    logic [LW-1:0] cnt_q; // fill level
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [PW-1:0] wr_next = (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
    wire [PW-1:0] rd_next = (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
    // honest flags straight from the level
    assign in_ready = (cnt_q != LW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign level = cnt_q;
    // ----------------------------------------------------------------
    // pointers and level
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_ptr_q <= wr_next;
            if (pop) rd_ptr_q <= rd_next;
            cnt_q <= cnt_q + LW'(push) - LW'(pop);
        end
    end
    // one write port per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mem_q[i] <= '0;
            end else if (push && wr_ptr_q == PW'(i)) begin
                mem_q[i] <= in_data;
            end
        end
    end
endmodule : word_buffer

// ===== verif/port_model.sv
// processor byte-port model: drives the glue pins and resolves the bus
`timescale 1ns/100ps
module port_model (
    input wire logic aclk, // system clock
    input wire logic [7:0] glue_byte, // byte the glue drives
    input wire logic glue_oe, // glue drive enable
    output logic copy_pulse, // copy pulse pin
    output logic read_strobe_n, // read strobe, active low
    output logic bus_output_enable_n, // output-enable, active low
    output logic bus_direction, // high on writes
    output logic addr_latch_n, // address latch, active low
    output logic [7:0] wire_level // resolved bus level
);
    logic [7:0] drv_byte; // byte we put on the bus
    logic drv_oe; // we drive the bus
    logic tick_q; // idle pattern toggle
    // ----------------------------------------------------------------
    // pins and bus
    // ----------------------------------------------------------------
    // mode 3 setup
    initial begin
        {copy_pulse, bus_direction, drv_oe, drv_byte, tick_q} = '0;
        {read_strobe_n, bus_output_enable_n, addr_latch_n} = '1;
    end
    // released bus changes each cycle so a stale byte never matches
    always @(posedge aclk) begin
        tick_q <= ~tick_q;
    end
    assign wire_level = drv_oe ? drv_byte : (glue_oe ? glue_byte : {4{tick_q, ~tick_q}});
    task automatic wait_clk(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_clk
    // pulses kept 4 clocks per level, above the 2-clock minimum
    task automatic pulse();
        copy_pulse <= 1'b1;
        wait_clk(4);
        copy_pulse <= 1'b0;
        wait_clk(4);
    endtask : pulse
    // capture copies, then pull bytes after strobe release
    task automatic read_word(input int ncap, output logic [31:0] got);
        read_strobe_n <= 1'b0;
        wait_clk(4);
        repeat (ncap) pulse();
        read_strobe_n <= 1'b1;
        bus_output_enable_n <= 1'b0;
        wait_clk(8);
        got[31:24] = wire_level;
        for (int i = 2; i >= 0; i--) begin
            pulse();
            got[i*8+:8] = wire_level;
        end
        bus_output_enable_n <= 1'b1;
        wait_clk(4);
    endtask : read_word
    task automatic write_word(input logic [31:0] w);
        {bus_output_enable_n, bus_direction, drv_oe} <= 3'b011;
        for (int i = 0; i < 4; i++) begin
            drv_byte <= w[i*8+:8];
            pulse();
        end
        {bus_output_enable_n, bus_direction, drv_oe} <= 3'b100;
        wait_clk(4);
    endtask : write_word
    // one address byte per clock
    task automatic addr_cycle(input logic [31:0] a);
        {addr_latch_n, drv_oe} <= 2'b01;
        for (int i = 3; i >= 0; i--) begin
            drv_byte <= a[i*8+:8];
            wait_clk(1);
        end
        {addr_latch_n, drv_oe} <= 2'b10;
        wait_clk(4);
    endtask : addr_cycle
endmodule : port_model

// ===== verif/testbench.sv
// self-checking bench for the byte-port glue
`timescale 1ns/100ps
module testbench;
    logic aclk, aresetn; // clock and reset
    logic copy_pulse, read_strobe_n, bus_output_enable_n, bus_direction, addr_latch_n; // pins
    logic [7:0] wire_level, muxed_byte_bus_o, s_axi_awaddr, s_axi_araddr; // bus and addresses
    logic muxed_byte_bus_oe, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // handshakes
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready; // handshakes
    logic [31:0] s_axi_wdata, s_axi_rdata, got; // data
    logic [3:0] s_axi_wstrb; // lanes
    logic [1:0] s_axi_bresp, s_axi_rresp, resp; // responses
    int num_errors = 0; // mismatches
    int comparisons = 0; // compares made
    byte_port_glue #(.BUF_DEPTH(2)) DUT (.aclk, .aresetn, .copy_pulse, .read_strobe_n, .bus_output_enable_n,
        .bus_direction, .addr_latch_n, .muxed_byte_bus_i(wire_level), .muxed_byte_bus_o, .muxed_byte_bus_oe,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    port_model mdl (.aclk, .glue_byte(muxed_byte_bus_o), .glue_oe(muxed_byte_bus_oe), .copy_pulse, .read_strobe_n,
        .bus_output_enable_n, .bus_direction, .addr_latch_n, .wire_level);
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_arready !== 1'b1) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    // masked read expecting an okay answer
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(name, d & m, e);
        check("rresp", {30'h0, r}, {30'h0, glue_pkg::RESP_OKAY});
    endtask : rd_chk
    task automatic print_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // ----------------------------------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // tests take a few hundred clocks
    initial begin
        repeat (30000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd_chk("ctrl", glue_pkg::OFF_CTRL, '1, glue_pkg::CTRL_RST);
        rd_chk("hold", glue_pkg::OFF_HOLD, '1, 32'h0000_0000);
        wr(glue_pkg::OFF_RDWORD, 32'ha1b2c3d4, glue_pkg::RESP_OKAY);
        mdl.read_word(2, got);
        check("read bytes", got, 32'ha1b2c3d4);
        rd_chk("hold", glue_pkg::OFF_HOLD, '1, 32'ha1b2c3d4);
        rd_chk("lane", glue_pkg::OFF_STATUS, 32'h0000_000e, 32'h0000_0000);
        mdl.write_word(32'h44332211);
        mdl.write_word(32'h8899aabb);
        mdl.write_word(32'hdeadbeef);
        rd_chk("full", glue_pkg::OFF_STATUS, 32'h0000_0071, 32'h0000_0061);
        rd_chk("wrword", glue_pkg::OFF_WRWORD, '1, 32'h44332211);
        rd_chk("wrword", glue_pkg::OFF_WRWORD, '1, 32'h8899aabb);
        rd_chk("empty", glue_pkg::OFF_WRWORD, '1, 32'h0000_0000);
        mdl.addr_cycle(32'hffbc_def0);
        rd_chk("addr", glue_pkg::OFF_ADDR, '1, 32'h01bc_def0);
        wr(glue_pkg::OFF_STATUS, 32'h0000_0001, glue_pkg::RESP_OKAY);
        rd_chk("cleared", glue_pkg::OFF_STATUS, 32'h0000_0071, 32'h0000_0000);
        wr(glue_pkg::OFF_HOLD, 32'h0000_0000, glue_pkg::RESP_SLVERR);
        rd(8'h1c, got, resp);
        check("unmapped", {resp, got[29:0]}, {glue_pkg::RESP_SLVERR, 30'h0});
        wr(glue_pkg::OFF_CTRL, glue_pkg::CTRL_RST | 32'h0000_0003, glue_pkg::RESP_OKAY);
        mdl.addr_cycle(32'h7ec3_5a69);
        rd_chk("boot addr", glue_pkg::OFF_ADDR, '1, 32'h007e_c35a);
        wr(glue_pkg::OFF_RDWORD, 32'h0f1e2d3c, glue_pkg::RESP_OKAY);
        mdl.read_word(0, got);
        check("sep read", got, 32'h0f1e2d3c);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd_chk("hold", glue_pkg::OFF_HOLD, '1, 32'h0000_0000);
        rd_chk("ctrl", glue_pkg::OFF_CTRL, '1, glue_pkg::CTRL_RST);
        print_verdict();
    end
endmodule : testbench
